// *** logic/fspc_ctrl.sv ***
`timescale 1ns/100ps
// Function
// - Operations last 3.7 to 4.5 ms, oscillator-timed.
// - System reset does not abort a running write.
// - Ready interrupt only while enable clear, idle.
// - Read-while-write busy bit reads zero.
// - Reserved bit five reads zero.
// - Read-enable write clears the page buffer.
// - Lock/fuse read via load within three cycles.
// - Page write command writes buffer to page.
// - Page write bit clears on finish or timeout.
// - CPU halted through the page write.
// - Page erase command erases addressed page.
// - Page erase bit clears on finish or timeout.
// - Store instruction allowed only four cycles.
// - Plain enable loads word into page buffer.
// - Enable clears after store or timeout.
// - Enable stays set while operation is busy.
// - Only five low-bit patterns take effect.
// - EEPROM write blocks programming and fuse reads.
// - Pointer selects low, lock, extended, high.
// - Buffer erased after page write and reset.
// - CPU halted through the page erase.
module fspc_ctrl
  import fspc_pkg::*;
#(
  parameter int PAGE_WORDS = 64,
  parameter int RC_FREQ_HZ = 1_000_000,
  parameter int OP_MIN_CYCLES = OP_MIN_CYC,
  parameter int OP_MAX_CYCLES = OP_MAX_CYC
)(
  input wire logic clock,
  input wire logic rst,
  input wire logic sys_reset,
  input wire logic rc_osc,
  input wire logic [5:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic spm_exec,
  input wire logic lpm_exec,
  input wire logic [15:0] z_ptr,
  input wire logic [15:0] r1r0,
  input wire logic eeprom_write_busy,
  input wire logic global_irq_enable,
  input wire logic [7:0] lock_bits,
  input wire logic [7:0] fuse_low,
  input wire logic [7:0] fuse_high,
  input wire logic [7:0] fuse_ext,
  output logic lpm_override,
  output logic [7:0] lpm_data,
  output logic cpu_halt,
  output logic prog_ready_irq,
  output logic flash_erase_req,
  output logic flash_write_req,
  output logic lock_write_req,
  output logic [7:0] lock_write_data,
  output logic [15:0] flash_page,
  input wire logic [$clog2(PAGE_WORDS)-1:0] pbuf_rd_idx,
  output logic [15:0] pbuf_rd_data
);

  localparam int IDX_W = $clog2(PAGE_WORDS);

  if (PAGE_WORDS < 2 || PAGE_WORDS > 4096 || (1 << IDX_W) != PAGE_WORDS) begin : g_bad_page
    $error("fspc_ctrl: page size must be a power of two from 2 to 4096 words");
  end

  function automatic logic cmd_legal(input logic [4:0] c);
    return (c == CMD_RWW_RD) || (c == CMD_LF_SEL) || (c == CMD_PG_WR) ||
           (c == CMD_PG_ER) || (c == CMD_LOAD);
  endfunction

  function automatic logic cmd_is_timed(input logic [4:0] c);
    return (c == CMD_PG_WR) || (c == CMD_PG_ER) || (c == CMD_LF_SEL);
  endfunction

  fspc_state_t state_r;
  logic [4:0] cmd_r;
  logic [2:0] win_r;
  logic irq_en_r;
  logic ee_busy_d_r;
  logic [7:0] io_rdata_r;
  logic [7:0] lpm_data_r;
  logic lpm_override_r;
  logic irq_r;
  logic erase_req_r;
  logic write_req_r;
  logic lock_req_r;
  logic [7:0] lock_data_r;
  logic [15:0] page_r;
  logic [15:0] pbuf_rd_r;
  logic [PAGE_WORDS-1:0] pbuf_vld_r;
  logic [15:0] pbuf_mem [PAGE_WORDS];

  logic reg_hit;
  logic wr_ok;
  logic arm_go;
  logic spm_take;
  logic lpm_take;
  logic tmr_busy;
  logic tmr_done;
  logic [7:0] status;
  logic [IDX_W-1:0] ld_idx;
  logic buf_clear;

  assign reg_hit = (io_addr == PCSR_ADDR);
  // EEPROM write blocks any new programming command
  assign wr_ok = io_wr && reg_hit && (state_r != ST_BUSY) && !eeprom_write_busy;
  // Any other low-bit pattern leaves the command state alone
  assign arm_go = wr_ok && cmd_legal(io_wdata[4:0]);
  // Store honoured only inside the armed window
  assign spm_take = spm_exec && (state_r == ST_ARMED) && (win_r < SPM_WIN) &&
                    !sys_reset;
  assign lpm_take = lpm_exec && (state_r == ST_ARMED) && (cmd_r == CMD_LF_SEL) &&
                    (win_r < LPM_WIN) && !eeprom_write_busy && !sys_reset;
  assign ld_idx = z_ptr[IDX_W:1];

  // Bits six and five are tied low; enable reflects armed or busy
  assign status = {irq_en_r, 1'b0, 1'b0, cmd_r[BIT_RWW_RD:BIT_PG_ER],
                   state_r != ST_IDLE};

  fspc_op_timer #(
    .RC_FREQ_HZ(RC_FREQ_HZ)
  ) u_timer (
    .clock(clock),
    .rst(rst),
    .rc_osc(rc_osc),
    .start(spm_take && cmd_is_timed(cmd_r)),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // Command sequencing; system reset spares a running operation
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cmd_r <= CMD_NONE;
      win_r <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (arm_go && !sys_reset) begin
            state_r <= ST_ARMED;
            cmd_r <= io_wdata[4:0];
            win_r <= '0;
          end
        end
        ST_ARMED: begin
          win_r <= win_r + 3'h1;
          if (sys_reset) begin
            state_r <= ST_IDLE;
            cmd_r <= CMD_NONE;
          end else if (spm_take && cmd_is_timed(cmd_r)) begin
            state_r <= ST_BUSY;
          end else if (spm_take || lpm_take || win_r == SPM_WIN - 3'h1) begin
            state_r <= ST_IDLE;
            cmd_r <= CMD_NONE;
          end
        end
        ST_BUSY: begin
          // Held through system reset until the timer finishes
          if (tmr_done || !tmr_busy) begin
            state_r <= ST_IDLE;
            cmd_r <= CMD_NONE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          cmd_r <= CMD_NONE;
        end
      endcase
    end
  end

  // Interrupt enable is writable even while an operation runs
  always_ff @(posedge clock) begin
    if (rst || sys_reset) begin
      irq_en_r <= PCSR_RESET[BIT_IRQ_EN];
    end else if (io_wr && reg_hit) begin
      irq_en_r <= io_wdata[BIT_IRQ_EN];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      io_rdata_r <= '0;
    end else begin
      io_rdata_r <= (io_rd && reg_hit) ? status : 8'h00;
    end
  end

  // Level request, silent during programming or EEPROM write
  always_ff @(posedge clock) begin
    if (rst || sys_reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_en_r && global_irq_enable && (state_r == ST_IDLE) &&
               !arm_go && !eeprom_write_busy;
    end
  end

  // Lock/fuse byte chosen by the pointer's low bits
  always_ff @(posedge clock) begin
    if (rst) begin
      lpm_data_r <= '0;
      lpm_override_r <= 1'b0;
    end else begin
      lpm_override_r <= lpm_take;
      if (lpm_take) begin
        case (z_ptr[1:0])
          LF_LOCK: lpm_data_r <= lock_bits;
          LF_FUSE_LOW: lpm_data_r <= fuse_low;
          LF_FUSE_HIGH: lpm_data_r <= fuse_high;
          LF_FUSE_EXT: lpm_data_r <= fuse_ext;
          default: lpm_data_r <= fuse_low;
        endcase
      end
    end
  end

  // One-cycle requests to the flash array
  always_ff @(posedge clock) begin
    if (rst) begin
      erase_req_r <= 1'b0;
      write_req_r <= 1'b0;
      lock_req_r <= 1'b0;
      lock_data_r <= '0;
      page_r <= '0;
    end else begin
      erase_req_r <= spm_take && (cmd_r == CMD_PG_ER);
      write_req_r <= spm_take && (cmd_r == CMD_PG_WR);
      lock_req_r <= spm_take && (cmd_r == CMD_LF_SEL);
      if (spm_take && cmd_is_timed(cmd_r)) begin
        page_r <= {z_ptr[15:IDX_W+1], {(IDX_W + 1){1'b0}}};
        lock_data_r <= r1r0[7:0];
      end
    end
  end

  // Buffer contents lost on reset, read-enable write, page write or EEPROM write
  always_ff @(posedge clock) begin
    if (rst) begin
      ee_busy_d_r <= 1'b0;
    end else begin
      ee_busy_d_r <= eeprom_write_busy;
    end
  end

  assign buf_clear = sys_reset || (arm_go && io_wdata[4:0] == CMD_RWW_RD) ||
                     (state_r == ST_BUSY && cmd_r == CMD_PG_WR && tmr_done) ||
                     (eeprom_write_busy && !ee_busy_d_r);

  always_ff @(posedge clock) begin
    if (rst) begin
      pbuf_vld_r <= '0;
    end else if (buf_clear) begin
      pbuf_vld_r <= '0;
    end else if (spm_take && cmd_r == CMD_LOAD) begin
      pbuf_vld_r[ld_idx] <= 1'b1;
    end
  end

  // Validity bits make a whole-buffer clear a single cycle
  always_ff @(posedge clock) begin
    if (spm_take && cmd_r == CMD_LOAD) begin
      pbuf_mem[ld_idx] <= r1r0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pbuf_rd_r <= ERASED_WORD;
    end else begin
      pbuf_rd_r <= pbuf_vld_r[pbuf_rd_idx] ? pbuf_mem[pbuf_rd_idx] : ERASED_WORD;
    end
  end

  assign io_rdata = io_rdata_r;
  assign lpm_data = lpm_data_r;
  assign lpm_override = lpm_override_r;
  assign cpu_halt = (state_r == ST_BUSY);
  assign prog_ready_irq = irq_r;
  assign flash_erase_req = erase_req_r;
  assign flash_write_req = write_req_r;
  assign lock_write_req = lock_req_r;
  assign lock_write_data = lock_data_r;
  assign flash_page = page_r;
  assign pbuf_rd_data = pbuf_rd_r;

  // Helper: cycles spent in the busy state
  logic [31:0] busy_cyc_r;
  always_ff @(posedge clock) begin
    if (rst || state_r != ST_BUSY) begin
      busy_cyc_r <= '0;
    end else begin
      busy_cyc_r <= busy_cyc_r + 32'h1;
    end
  end

  op_max_time_a: assert property (@(posedge clock) disable iff (rst)
    busy_cyc_r <= 32'(OP_MAX_CYCLES))
    else $error("operation ran past the longest time");

  op_min_time_a: assert property (@(posedge clock) disable iff (rst)
    (state_r == ST_BUSY) ##1 (state_r == ST_IDLE) |-> $past(busy_cyc_r) >= 32'(OP_MIN_CYCLES - 1))
    else $error("operation ended before the least time");

  rww_res_zero_a: assert property (@(posedge clock) disable iff (rst)
    (io_rd && reg_hit) |=> (io_rdata[BIT_RWW_BUSY] == 1'b0) && (io_rdata[BIT_RSVD] == 1'b0))
    else $error("busy or reserved bit read as one");

  irq_quiet_a: assert property (@(posedge clock) disable iff (rst)
    (state_r != ST_IDLE || eeprom_write_busy) |=> !prog_ready_irq)
    else $error("ready interrupt raised while busy");

  window_close_a: assert property (@(posedge clock) disable iff (rst)
    (state_r == ST_IDLE && arm_go && !sys_reset) ##1
    (!spm_exec && !lpm_exec && !sys_reset) [*4] |=> (state_r == ST_IDLE) && (cmd_r == CMD_NONE))
    else $error("armed window did not close after four cycles");

  bad_pattern_a: assert property (@(posedge clock) disable iff (rst)
    (state_r == ST_IDLE && wr_ok && !cmd_legal(io_wdata[4:0])) |=> (state_r == ST_IDLE))
    else $error("illegal pattern took effect");

  halt_erase_a: assert property (@(posedge clock) disable iff (rst)
    (spm_take && cmd_r == CMD_PG_ER) |=> flash_erase_req && cpu_halt && status[BIT_SP_EN])
    else $error("page erase did not start with halt");

  buf_wipe_a: assert property (@(posedge clock) disable iff (rst)
    (state_r == ST_BUSY && cmd_r == CMD_PG_WR && tmr_done) |=> (pbuf_vld_r == '0) && !cpu_halt)
    else $error("page buffer kept data after page write");

  reset_keeps_op_a: assert property (@(posedge clock) disable iff (rst)
    (state_r == ST_BUSY && sys_reset && !tmr_done) |=> cpu_halt && status[BIT_SP_EN])
    else $error("system reset aborted a running operation");

  no_ee_program_a: assert property (@(posedge clock) disable iff (rst)
    (state_r == ST_IDLE && eeprom_write_busy) |=> (state_r == ST_IDLE))
    else $error("programming armed during EEPROM write");

endmodule

// *** logic/fspc_op_timer.sv ***
`timescale 1ns/100ps
module fspc_op_timer
  import fspc_pkg::*;
#(
  parameter int RC_FREQ_HZ = 1_000_000
)(
  input wire logic clock,
  input wire logic rst,
  input wire logic rc_osc,
  input wire logic start,
  output logic busy,
  output logic done
);

  // Least time rounds up in oscillator ticks, longest rounds down
  localparam longint TICKS_MIN = (OP_MIN_NS * RC_FREQ_HZ + NS_PER_S - 1) / NS_PER_S;
  localparam longint TICKS_MAX = (OP_MAX_NS * RC_FREQ_HZ) / NS_PER_S;
  // First tick may land just after start, so one extra edge is counted
  localparam int CW = $clog2(TICKS_MIN + 2);
  localparam logic [CW-1:0] TICKS = CW'(TICKS_MIN + 1);

  if (TICKS_MIN < 1 || TICKS_MIN + 1 > TICKS_MAX || RC_FREQ_HZ * 2 > CLK_HZ) begin : g_bad_rc
    $error("fspc_op_timer: oscillator rate cannot time the operation");
  end

  logic rc_meta_r;
  logic rc_sync_r;
  logic rc_prev_r;
  logic [CW-1:0] cnt_r;
  logic busy_r;

  // Oscillator is asynchronous; first stage feeds only the second
  always_ff @(posedge clock) begin
    if (rst) begin
      rc_meta_r <= 1'b0;
      rc_sync_r <= 1'b0;
      rc_prev_r <= 1'b0;
    end else begin
      rc_meta_r <= rc_osc;
      rc_sync_r <= rc_meta_r;
      rc_prev_r <= rc_sync_r;
    end
  end

  // Duration counted in calibrated oscillator ticks
  always_ff @(posedge clock) begin
    if (rst) begin
      busy_r <= 1'b0;
      cnt_r <= '0;
    end else if (start && !busy_r) begin
      busy_r <= 1'b1;
      cnt_r <= '0;
    end else if (busy_r && rc_sync_r && !rc_prev_r) begin
      if (cnt_r == TICKS - CW'(1)) begin
        busy_r <= 1'b0;
      end
      cnt_r <= cnt_r + CW'(1);
    end
  end

  assign busy = busy_r;
  assign done = busy_r && rc_sync_r && !rc_prev_r && (cnt_r == TICKS - CW'(1));

endmodule

// *** logic/fspc_pkg.sv ***
package fspc_pkg;

  // Register location on the I/O bus
  localparam logic [5:0] PCSR_ADDR = 6'h37;
  localparam logic [7:0] PCSR_RESET = 8'h00;

  // Bit positions inside the control/status register
  localparam int BIT_IRQ_EN = 7;
  localparam int BIT_RWW_BUSY = 6;
  localparam int BIT_RSVD = 5;
  localparam int BIT_RWW_RD = 4;
  localparam int BIT_LF_SEL = 3;
  localparam int BIT_PG_WR = 2;
  localparam int BIT_PG_ER = 1;
  localparam int BIT_SP_EN = 0;

  // Accepted patterns of the low five bits, then the idle command value
  localparam logic [4:0] CMD_RWW_RD = 5'h11;
  localparam logic [4:0] CMD_LF_SEL = 5'h09;
  localparam logic [4:0] CMD_PG_WR = 5'h05;
  localparam logic [4:0] CMD_PG_ER = 5'h03;
  localparam logic [4:0] CMD_LOAD = 5'h01;
  localparam logic [4:0] CMD_NONE = 5'h00;

  // Lock/fuse read selector values
  localparam logic [1:0] LF_FUSE_LOW = 2'h0;
  localparam logic [1:0] LF_LOCK = 2'h1;
  localparam logic [1:0] LF_FUSE_EXT = 2'h2;
  localparam logic [1:0] LF_FUSE_HIGH = 2'h3;

  // Instruction windows in clock cycles
  localparam logic [2:0] SPM_WIN = 3'h4;
  localparam logic [2:0] LPM_WIN = 3'h3;

  // Operation time limits and system clock
  localparam longint OP_MIN_NS = 3_700_000;
  localparam longint OP_MAX_NS = 4_500_000;
  localparam longint CLK_HZ = 25_000_000;
  localparam longint NS_PER_S = 1_000_000_000;
  localparam int OP_MIN_CYC = int'((OP_MIN_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
  localparam int OP_MAX_CYC = int'((OP_MAX_NS * CLK_HZ) / NS_PER_S);

  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_BUSY = 3'b100
  } fspc_state_t;

endpackage

// *** tb/fspc_cpu_model.sv ***
`timescale 1ns/100ps
module fspc_cpu_model
  import fspc_pkg::*;
(
  input wire logic clock,
  input wire logic [7:0] io_rdata,
  input wire logic cpu_halt,
  output logic [5:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata,
  output logic spm_exec,
  output logic lpm_exec,
  output logic [15:0] z_ptr,
  output logic [15:0] r1r0
);
  initial begin
    io_addr = PCSR_ADDR;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
    spm_exec = 1'b0;
    lpm_exec = 1'b0;
    z_ptr = 16'h0000;
    r1r0 = 16'h0000;
  end

  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(negedge clock);
    io_addr = a;
    io_wdata = v;
    io_wr = 1'b1;
    @(negedge clock);
    io_wr = 1'b0;
    io_wdata = ~v;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    @(negedge clock);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clock);
    io_rd = 1'b0;
    v = io_rdata;
  endtask

  // k: window edge at which the instruction is taken
  task automatic instr(input int k, input logic is_spm, input logic [15:0] z,
                       input logic [15:0] d);
    while (cpu_halt === 1'b1) @(negedge clock);
    repeat (k - 1) @(negedge clock);
    z_ptr = z;
    r1r0 = d;
    spm_exec = is_spm;
    lpm_exec = !is_spm;
    @(negedge clock);
    spm_exec = 1'b0;
    lpm_exec = 1'b0;
    // Operands not left at their last value
    z_ptr = ~z;
    r1r0 = ~d;
  endtask

  // Portable loaders also wait on the busy flag
  task automatic poll_ready(output logic ok);
    logic [7:0] s;
    ok = 1'b0;
    for (int i = 0; i < 300 && !ok; i++) begin
      @(negedge clock);
      if (cpu_halt !== 1'b1) begin
        rd(PCSR_ADDR, s);
        ok = (s[BIT_SP_EN] === 1'b0) && (s[BIT_RWW_BUSY] === 1'b0);
      end
    end
  endtask
endmodule

// *** tb/test_flash_self_program_control.sv ***
`timescale 1ns/100ps
module test_flash_self_program_control
  import fspc_pkg::*;
;
  localparam int TICK_CYC = 10;
  // 3.7 and 4.5 ms in 200 us oscillator ticks of TICK_CYC clocks each
  localparam int OP_MIN_CLK = 37 * TICK_CYC / 2;
  localparam int OP_MAX_CLK = 45 * TICK_CYC / 2;
  localparam logic [7:0] BAD [6] = '{8'h87, 8'h90, 8'h9F, 8'h82, 8'h84, 8'h88};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic sys_reset = 1'b0;
  logic rc_osc = 1'b0;
  logic eeprom_write_busy = 1'b0;
  logic global_irq_enable = 1'b1;
  logic [5:0] pbuf_rd_idx = 6'h00;
  logic [5:0] io_addr;
  logic io_wr, io_rd, spm_exec, lpm_exec, lpm_override, cpu_halt, prog_ready_irq;
  logic flash_erase_req, flash_write_req, lock_write_req, ok;
  logic [7:0] io_wdata, io_rdata, lpm_data, lock_write_data, s;
  logic [15:0] z_ptr, r1r0, flash_page, pbuf_rd_data;
  logic [7:0] fuse_b [4] = '{8'h62, 8'hFC, 8'hFD, 8'hD9};
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  time t0;

  always #20 clock = ~clock;
  initial begin
    #7;
    forever #(TICK_CYC * 20) rc_osc = ~rc_osc;
  end

  fspc_ctrl #(.PAGE_WORDS(64), .RC_FREQ_HZ(5000), .OP_MIN_CYCLES(OP_MIN_CLK),
    .OP_MAX_CYCLES(OP_MAX_CLK)) dut (
    .clock(clock), .rst(rst), .sys_reset(sys_reset), .rc_osc(rc_osc), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .spm_exec(spm_exec), .lpm_exec(lpm_exec), .z_ptr(z_ptr), .r1r0(r1r0),
    .eeprom_write_busy(eeprom_write_busy), .global_irq_enable(global_irq_enable),
    .lock_bits(fuse_b[1]), .fuse_low(fuse_b[0]), .fuse_high(fuse_b[3]), .fuse_ext(fuse_b[2]),
    .lpm_override(lpm_override), .lpm_data(lpm_data), .cpu_halt(cpu_halt),
    .prog_ready_irq(prog_ready_irq), .flash_erase_req(flash_erase_req),
    .flash_write_req(flash_write_req), .lock_write_req(lock_write_req),
    .lock_write_data(lock_write_data), .flash_page(flash_page),
    .pbuf_rd_idx(pbuf_rd_idx), .pbuf_rd_data(pbuf_rd_data)
  );

  fspc_cpu_model cpu (
    .clock(clock), .io_rdata(io_rdata), .cpu_halt(cpu_halt), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .spm_exec(spm_exec),
    .lpm_exec(lpm_exec), .z_ptr(z_ptr), .r1r0(r1r0)
  );

  task automatic report_and_stop;
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
    cpu.rd(a, s);
    chk({8'h00, s}, {8'h00, exp});
  endtask

  task automatic bufchk(input logic [5:0] idx, input logic [15:0] exp);
    @(negedge clock);
    pbuf_rd_idx = idx;
    @(negedge clock);
    chk(pbuf_rd_data, exp);
  endtask

  // Halt length in clocks, against the scaled oscillator tick count
  task automatic finish_op;
    int n;
    n = 0;
    while (cpu_halt === 1'b1 && n < 1000) begin
      @(negedge clock);
      n++;
    end
    n = int'(($time - t0) / 40);
    chk({15'h0, n >= OP_MIN_CLK && n <= OP_MAX_CLK}, 16'h1);
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  initial begin
    repeat (8) @(negedge clock);
    rst = 1'b0;
    rdchk(PCSR_ADDR, PCSR_RESET);
    cpu.wr(PCSR_ADDR, 8'hFF);
    rdchk(PCSR_ADDR, 8'h80);
    chk({15'h0, prog_ready_irq}, 16'h1);
    for (int i = 0; i < 6; i++) begin
      cpu.wr(PCSR_ADDR, BAD[i]);
      rdchk(PCSR_ADDR, 8'h80);
    end
    cpu.wr(6'h36, 8'h81);
    rdchk(6'h36, 8'h00);
    rdchk(PCSR_ADDR, 8'h80);
    cpu.wr(PCSR_ADDR, 8'h81);
    cpu.instr(4, 1'b1, 16'h000B, 16'hA5C3);
    rdchk(PCSR_ADDR, 8'h80);
    bufchk(6'h05, 16'hA5C3);
    cpu.wr(PCSR_ADDR, 8'h81);
    repeat (4) @(negedge clock);
    cpu.instr(1, 1'b1, 16'h0004, 16'h1111);
    rdchk(PCSR_ADDR, 8'h80);
    bufchk(6'h02, ERASED_WORD);
    cpu.wr(PCSR_ADDR, 8'h91);
    bufchk(6'h05, ERASED_WORD);
    repeat (4) @(negedge clock);
    cpu.wr(PCSR_ADDR, 8'h81);
    cpu.instr(1, 1'b1, 16'h000A, 16'h5A5A);
    cpu.wr(PCSR_ADDR, 8'h83);
    cpu.instr(1, 1'b1, 16'h0ABC, 16'h2222);
    t0 = $time;
    chk({15'h0, flash_erase_req}, 16'h1);
    chk(flash_page, 16'h0A80);
    chk({15'h0, cpu_halt}, 16'h1);
    chk({15'h0, prog_ready_irq}, 16'h0);
    rdchk(PCSR_ADDR, 8'h83);
    @(negedge clock);
    sys_reset = 1'b1;
    @(negedge clock);
    sys_reset = 1'b0;
    chk({15'h0, cpu_halt}, 16'h1);
    finish_op();
    rdchk(PCSR_ADDR, 8'h00);
    bufchk(6'h05, ERASED_WORD);
    cpu.wr(PCSR_ADDR, 8'h01);
    cpu.instr(2, 1'b1, 16'h0006, 16'h1357);
    bufchk(6'h03, 16'h1357);
    cpu.wr(PCSR_ADDR, 8'h05);
    cpu.instr(1, 1'b1, 16'h0A80, 16'h0000);
    t0 = $time;
    chk({15'h0, flash_write_req}, 16'h1);
    chk(flash_page, 16'h0A80);
    chk({15'h0, cpu_halt}, 16'h1);
    finish_op();
    rdchk(PCSR_ADDR, 8'h00);
    bufchk(6'h03, ERASED_WORD);
    cpu.wr(PCSR_ADDR, 8'h09);
    cpu.instr(2, 1'b1, 16'h0001, 16'h00F3);
    t0 = $time;
    chk({15'h0, lock_write_req}, 16'h1);
    chk({8'h00, lock_write_data}, 16'h00F3);
    finish_op();
    cpu.poll_ready(ok);
    chk({15'h0, ok}, 16'h1);
    for (int i = 0; i < 4; i++) begin
      cpu.wr(PCSR_ADDR, 8'h09);
      cpu.instr(3, 1'b0, 16'(i), 16'h0000);
      chk({15'h0, lpm_override}, 16'h1);
      chk({8'h00, lpm_data}, {8'h00, fuse_b[i]});
      repeat (4) @(negedge clock);
    end
    cpu.wr(PCSR_ADDR, 8'h09);
    cpu.instr(4, 1'b0, 16'h0001, 16'h0000);
    chk({15'h0, lpm_override}, 16'h0);
    cpu.wr(PCSR_ADDR, 8'h05);
    cpu.instr(5, 1'b1, 16'h0A80, 16'h0000);
    chk({15'h0, cpu_halt}, 16'h0);
    rdchk(PCSR_ADDR, 8'h00);
    cpu.wr(PCSR_ADDR, 8'h03);
    cpu.instr(5, 1'b1, 16'h0A80, 16'h0000);
    chk({15'h0, cpu_halt}, 16'h0);
    rdchk(PCSR_ADDR, 8'h00);
    eeprom_write_busy = 1'b1;
    cpu.wr(PCSR_ADDR, 8'h89);
    rdchk(PCSR_ADDR, 8'h80);
    cpu.instr(1, 1'b0, 16'h0001, 16'h0000);
    chk({15'h0, lpm_override}, 16'h0);
    chk({15'h0, prog_ready_irq}, 16'h0);
    eeprom_write_busy = 1'b0;
    repeat (2) @(negedge clock);
    chk({15'h0, prog_ready_irq}, 16'h1);
    global_irq_enable = 1'b0;
    repeat (2) @(negedge clock);
    chk({15'h0, prog_ready_irq}, 16'h0);
    report_and_stop();
  end
endmodule
